/* core/i2css_core.sv */
// Two-wire bus slave with acknowledge handling and clock stretching
// Contract
// - Slave matches 7-bit own address followed by R/W, or 10-bit own address with R/W at the end of the first byte.
// - 10-bit address comes as two bytes; first byte's top five bits mark it.
// - Data moves in whole bytes, any number per transfer.
// - As receiver, slave acknowledges its address bytes and each data byte taken while rx_ready is high.
// - When not acknowledging, slave leaves SDA released high.
// - Slave transmitter releases SDA after master not-acknowledge.
// - STOP during the acknowledge clock is a valid end.
// - Slave may hold SCL low to delay the next byte.
// - Stretching happens only after the acknowledge bit, not between individual bits.
// - Transmitter stretches automatically; receiver does not by default.
// - Receive stretching only when control bit 4 is cleared.
module i2css_core
   import i2css_pkg::*;
(
   input  wire logic              core_clk,      // System clock, 50 MHz
   input  wire logic              rst,           // Async reset, active high
   input  wire i2css_pkg::i2css_cfg_s cfg,       // Own address and format
   input  wire logic [7:0]        serial_port_control, // Control byte
   input  wire logic              scl_i,         // SCL pin level
   output logic                   scl_o,         // SCL drive value (always 0)
   output logic                   scl_oe,        // SCL pulled low while high
   input  wire logic              sda_i,         // SDA pin level
   output logic                   sda_o,         // SDA drive value (always 0)
   output logic                   sda_oe,        // SDA pulled low while high
   output i2css_pkg::i2css_rx_s   rx,            // Received byte
   output logic                   rx_valid,      // Pulse: rx holds new byte
   output logic                   rx_nack,       // Pulse: byte not acknowledged
   input  wire logic              rx_ready,      // User can take a byte
   input  wire logic [7:0]        tx_data,       // Byte to send
   input  wire logic              tx_valid,      // tx_data is ready
   output logic                   tx_ready,      // Pulse: tx_data taken
   output logic                   busy,          // Addressed, inside a transfer
   output logic                   reading,       // Addressed for master read
   output logic                   stop_seen      // Pulse: STOP detected
);
   logic scl, scl_rise, scl_fall, sda, sda_rise, sda_fall;
   i2css_state_e state_r, state_nxt;
   logic [7:0] shift_r;
   logic [2:0] bit_r;
   logic       addr_phase_r, second_r, match_r, rw_r, ack_drv_r, tx_drv_r;
   logic       hold_r, active_r, ack_due_r;

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   i2css_sync u_scl (
      .core_clk (core_clk),
      .rst      (rst),
      .pin_i    (scl_i),
      .level    (scl),
      .rise     (scl_rise),
      .fall     (scl_fall)
   );
   i2css_sync u_sda (
      .core_clk (core_clk),
      .rst      (rst),
      .pin_i    (sda_i),
      .level    (sda),
      .rise     (sda_rise),
      .fall     (sda_fall)
   );

   // ---------------------------------------------------------------
   // Decode
   // ---------------------------------------------------------------
   wire start_det = sda_fall & scl;
   wire stop_det  = sda_rise & scl;
   wire [7:0] byte_in = {shift_r[6:0], sda};
   wire first_10  = byte_in[7:3] == TEN_BIT_MARK;
   // First byte: 7-bit address or 10-bit mark plus high bits
   wire hit7  = ~cfg.ten_bit & (byte_in[7:1] == cfg.addr[6:0]);
   wire hit10 = cfg.ten_bit & first_10
                & (byte_in[2:1] == cfg.addr[9:8]);
   wire hit10b = byte_in == cfg.addr[7:0];
   wire last_bit = bit_r == LAST_BIT;
   // Receive stretching only with control bit cleared; a full consumer gets a NACK
   wire rx_stretch_en = ~serial_port_control[STRETCH_BIT];
   wire need_rx_hold = rx_stretch_en;

   // ---------------------------------------------------------------
   // Next-state decode
   // ---------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE:     state_nxt = ST_IDLE;
         ST_BYTE:     if (scl_rise && last_bit) state_nxt = ST_ACK;
         ST_ACK:      if (scl_fall) state_nxt = ST_MACK;
         ST_ACK_HOLD: state_nxt = ST_BYTE;
         ST_MACK:     if (scl_fall) state_nxt = ST_ACK_HOLD;
         ST_STRETCH:  if (~hold_r) state_nxt = ST_BYTE;
         default:     state_nxt = ST_IDLE;
      endcase
      if (stop_det) state_nxt = ST_IDLE;
      if (start_det) state_nxt = ST_BYTE;
   end

   // ---------------------------------------------------------------
   // Byte engine: shifts bits on SCL rise, drives SDA after SCL fall
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_r      <= ST_IDLE;
         shift_r      <= 8'h00;
         bit_r        <= 3'h0;
         addr_phase_r <= 1'b0;
         second_r     <= 1'b0;
         match_r      <= 1'b0;
         rw_r         <= 1'b0;
         ack_drv_r    <= 1'b0;
         tx_drv_r     <= 1'b0;
         hold_r       <= 1'b0;
         active_r     <= 1'b0;
         ack_due_r    <= 1'b0;
         rx           <= '0;
         rx_valid     <= 1'b0;
         rx_nack      <= 1'b0;
         tx_ready     <= 1'b0;
         stop_seen    <= 1'b0;
      end else begin
         state_r   <= state_nxt;
         rx_valid  <= 1'b0;
         rx_nack   <= 1'b0;
         tx_ready  <= 1'b0;
         stop_seen <= stop_det;
         if (start_det) begin
            // Repeated start keeps 10-bit match for the read turnaround
            bit_r        <= 3'h0;
            addr_phase_r <= 1'b1;
            second_r     <= 1'b0;
            ack_drv_r    <= 1'b0;
            tx_drv_r     <= 1'b0;
            hold_r       <= 1'b0;
            active_r     <= 1'b0;
         end else if (stop_det) begin
            // Release both lines at once, also mid acknowledge
            ack_drv_r <= 1'b0;
            tx_drv_r  <= 1'b0;
            hold_r    <= 1'b0;
            active_r  <= 1'b0;
            match_r   <= 1'b0;
         end else begin
            case (state_r)
               ST_BYTE: begin
                  if (scl_rise) begin
                     shift_r <= byte_in;
                     bit_r   <= bit_r + 3'h1;
                  end
                  if (scl_fall && active_r && rw_r)
                     tx_drv_r <= ~shift_r[7];
                  if (scl_rise && last_bit) begin
                     bit_r     <= 3'h0;
                     ack_due_r <= 1'b0;
                     if (addr_phase_r && !second_r) begin
                        rw_r <= byte_in[0];
                        if (hit7) begin
                           addr_phase_r <= 1'b0;
                           active_r     <= 1'b1;
                           ack_due_r    <= 1'b1;
                        end else if (hit10 && byte_in[0] && match_r) begin
                           addr_phase_r <= 1'b0;
                           active_r     <= 1'b1;
                           ack_due_r    <= 1'b1;
                        end else if (hit10 && !byte_in[0]) begin
                           second_r  <= 1'b1;
                           ack_due_r <= 1'b1;
                        end else begin
                           addr_phase_r <= 1'b0;
                        end
                     end else if (second_r) begin
                        second_r     <= 1'b0;
                        addr_phase_r <= 1'b0;
                        match_r      <= hit10b;
                        active_r     <= hit10b;
                        ack_due_r    <= hit10b;
                     end else if (active_r && !rw_r) begin
                        rx.data    <= byte_in;
                        rx.is_addr <= 1'b0;
                        rx_valid   <= rx_ready;
                        rx_nack    <= ~rx_ready;
                        ack_due_r  <= rx_ready;
                     end
                  end
               end
               // Ack waits for the eighth fall: SDA moving with SCL high reads as START
               ST_ACK: begin
                  if (scl_fall) begin
                     ack_drv_r <= ack_due_r;
                     tx_drv_r  <= 1'b0;
                  end
               end
               // Ninth bit: master acknowledge in, own acknowledge out
               ST_MACK: begin
                  if (scl_rise && active_r && rw_r && !ack_drv_r && sda)
                     active_r <= 1'b0;
                  if (scl_fall) begin
                     ack_drv_r <= 1'b0;
                     tx_drv_r  <= 1'b0;
                     // Transmit holds SCL unless the master refused the byte; receive only when allowed
                     if (active_r && rw_r)
                        hold_r <= 1'b1;
                     else if (active_r && need_rx_hold)
                        hold_r <= 1'b1;
                  end
               end
               ST_ACK_HOLD: ;
               default: ;
            endcase
            // Release SCL once data can flow again
            if (hold_r && state_r != ST_MACK) begin
               if (rw_r && tx_valid) begin
                  shift_r  <= tx_data;
                  tx_drv_r <= ~tx_data[7];
                  tx_ready <= 1'b1;
                  hold_r   <= 1'b0;
               end else if (!rw_r && rx_ready) begin
                  hold_r <= 1'b0;
               end
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Open-drain outputs: drive only low
   // ---------------------------------------------------------------
   assign sda_o   = 1'b0;
   assign scl_o   = 1'b0;
   assign sda_oe  = ack_drv_r | tx_drv_r;
   assign scl_oe  = hold_r;
   assign busy    = active_r;
   assign reading = active_r & rw_r;
endmodule // i2css_core

/* core/i2css_pkg.sv */
// Package: shared types and constants of the two-wire slave block
package i2css_pkg;
   // ---------------------------------------------------------------
   // Address formats, byte width and bit constants
   // ---------------------------------------------------------------
   localparam int          ADDR7_W       = 7;
   localparam int          ADDR10_W      = 10;
   localparam logic [4:0]  TEN_BIT_MARK  = 5'h1e;   // Leading pattern of a 10-bit first byte
   localparam int          BYTE_W        = 8;
   localparam logic [2:0]  LAST_BIT      = 3'h7;
   localparam int          STRETCH_BIT   = 4;       // Control bit that gates receive stretching

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic ten_bit;        // Use 10-bit address format
      logic [9:0] addr;     // Own address, 7 bits in [6:0] when ten_bit low
   } i2css_cfg_s;

   typedef struct packed {
      logic [7:0] data;     // Received byte
      logic       is_addr;  // Byte was an address byte
   } i2css_rx_s;

   typedef enum logic [2:0] {
      ST_IDLE, ST_BYTE, ST_ACK, ST_ACK_HOLD, ST_MACK, ST_STRETCH
   } i2css_state_e;
endpackage : i2css_pkg

/* core/i2css_sync.sv */
// Two-flop synchroniser with edge detection for one bus line
module i2css_sync (
   input  wire logic core_clk,   // System clock
   input  wire logic rst,        // Async reset, active high
   input  wire logic pin_i,      // Raw pin level
   output logic      level,      // Synchronised level
   output logic      rise,       // One-cycle rising pulse
   output logic      fall        // One-cycle falling pulse
);
   logic meta_r, sync_r, last_r;

   // ---------------------------------------------------------------
   // Synchroniser; lines idle high so reset to one
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         meta_r <= 1'b1;
         sync_r <= 1'b1;
         last_r <= 1'b1;
      end else begin
         meta_r <= pin_i;
         sync_r <= meta_r;
         last_r <= sync_r;
      end
   end

   // Edges compare only second and third flops
   assign level = sync_r;
   assign rise  = sync_r & ~last_r;
   assign fall  = ~sync_r & last_r;
endmodule // i2css_sync

/* sim/i2css_core_asserts.sv */
// Checker: port-level properties of the two-wire slave core
module i2css_core_asserts
   import i2css_pkg::*;
(
   input wire logic       core_clk,            // Clock
   input wire logic       rst,                 // Reset
   input wire logic [7:0] serial_port_control, // Control byte
   input wire logic       scl_oe,              // SCL pull
   input wire logic       sda_oe,              // SDA pull
   input wire logic       rx_valid,            // Byte taken
   input wire logic       rx_nack,             // Byte refused
   input wire logic       tx_valid,            // Byte offered
   input wire logic       tx_ready,            // Byte taken
   input wire logic       busy,                // Addressed
   input wire logic       reading,             // Master read
   input wire logic       stop_seen            // STOP pulse
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   // Acknowledge must follow a taken byte within one bit time
   property p_ack; rx_valid |-> ##[0:12] sda_oe; endproperty
   a_ack: assert property (p_ack) else $error("no ack after byte");
   property p_nack; rx_nack |-> !sda_oe [*8]; endproperty
   a_nack: assert property (p_nack) else $error("sda held on refusal");
   property p_nostr; busy && !reading && serial_port_control[STRETCH_BIT] |-> !scl_oe; endproperty
   a_nostr: assert property (p_nostr) else $error("receive stretch while off");
   property p_hold; scl_oe && reading && !tx_valid |=> scl_oe; endproperty
   a_hold: assert property (p_hold) else $error("stretch dropped early");
   property p_txrel; tx_ready |-> ##[0:4] !scl_oe; endproperty
   a_txrel: assert property (p_txrel) else $error("scl kept after byte");
   property p_txh; tx_ready |-> $past(tx_valid); endproperty
   a_txh: assert property (p_txh) else $error("byte taken unoffered");
   property p_stop; stop_seen |-> ##[0:2] !busy; endproperty
   a_stop: assert property (p_stop) else $error("busy after stop");
   property p_fell; $fell(busy) |-> ##[0:2] (!sda_oe && !scl_oe); endproperty
   a_fell: assert property (p_fell) else $error("lines held after end");
   c_wr: cover property (rx_valid);
   c_rd: cover property (tx_ready);
   c_str: cover property (scl_oe && !reading);
   c_stp: cover property (stop_seen);
endmodule // i2css_core_asserts

bind i2css_core i2css_core_asserts i2css_core_asserts_i (
   .core_clk(core_clk), .rst(rst), .serial_port_control(serial_port_control),
   .scl_oe(scl_oe), .sda_oe(sda_oe), .rx_valid(rx_valid), .rx_nack(rx_nack),
   .tx_valid(tx_valid), .tx_ready(tx_ready), .busy(busy), .reading(reading),
   .stop_seen(stop_seen)
);

/* sim/i2css_core_tb_top.sv */
// Testbench: slave core against a bus master model
module i2css_core_tb_top
   import i2css_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        core_clk = 1'b0, rst = 1'b1, rx_ready = 1'b1, tx_valid = 1'b0;
   logic        scl_oe, sda_oe, rx_valid, rx_nack, tx_ready, busy, reading, stop_seen;
   logic        m_scl_oe, m_sda_oe, ack;
   logic [7:0]  serial_port_control = 8'h10, tx_data = 8'h00, q, exp_wr[$], exp_rd[$];
   logic [31:0] seed = 32'h0000affa;
   int          error_cnt = 0, cmp_count = 0, dly = 0;
   i2css_cfg_s  cfg = '0;
   i2css_rx_s   rx;
   wire         scl = !(m_scl_oe | scl_oe); // Pull-ups on both lines
   wire         sda = !(m_sda_oe | sda_oe);
   always #10 core_clk = !core_clk;
   i2css_core i2css_core_i (
      .core_clk(core_clk), .rst(rst), .cfg(cfg), .serial_port_control(serial_port_control),
      .scl_i(scl), .scl_o(), .scl_oe(scl_oe), .sda_i(sda), .sda_o(), .sda_oe(sda_oe),
      .rx(rx), .rx_valid(rx_valid), .rx_nack(rx_nack), .rx_ready(rx_ready), .tx_data(tx_data),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .busy(busy), .reading(reading),
      .stop_seen(stop_seen));
   i2css_master_model master (.scl(scl), .sda(sda), .scl_oe(m_scl_oe), .sda_oe(m_sda_oe));
   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_ack(input logic exp);
      chk({7'h00, ack}, {7'h00, exp});
   endtask
   task automatic end_sim();
      if (error_cnt == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Address phase in the configured format
   task automatic address(input logic rd, input logic [9:0] a, input logic exp);
      if (cfg.ten_bit) begin
         master.xfer({TEN_BIT_MARK, a[9:8], 1'b0}, 1'b1, 1'b0, q, ack);
         chk_ack(1'b0);
         master.xfer(a[7:0], 1'b1, 1'b0, q, ack);
         chk_ack(exp);
         if (rd) begin
            master.start();
            master.xfer({TEN_BIT_MARK, a[9:8], 1'b1}, 1'b1, 1'b0, q, ack);
            chk_ack(exp);
         end
      end else begin
         master.xfer({a[6:0], rd}, 1'b1, 1'b0, q, ack);
         chk_ack(exp);
      end
   endtask
   // Bytes for master reads with random gaps, so transmit stretching shows
   always @(negedge core_clk) begin
      if (tx_ready === 1'b1) begin
         exp_rd.push_back(tx_data);
         tx_data = rnd();
         tx_valid = 1'b0;
         dly = rnd() % 40;
      end else if (dly > 0) dly--;
      else tx_valid = 1'b1;
   end
   // Each reported byte against the oldest note
   always @(negedge core_clk) if (rx_valid === 1'b1)
      chk(rx.data, exp_wr.size() ? exp_wr.pop_front() : 8'hxx);
   initial begin
      #1_000_000;
      error_cnt++;
      end_sim();
   end
   initial begin
      logic [9:0] a;
      logic [7:0] d;
      repeat (8) @(posedge core_clk);
      @(negedge core_clk) rst = 1'b0;
      for (int md = 0; md < 4; md++) begin
         repeat (4) @(negedge core_clk);
         chk({7'h00, busy}, 8'h00);
         d = rnd();
         a = md[1] ? {2'(d), rnd()} : {4'h0, 6'(rnd())};
         cfg = '{ten_bit: md[1], addr: a};
         serial_port_control = {d[7:5], md[0], d[3:0]};
         master.start();
         address(1'b0, a, 1'b0);
         for (int i = 0; i < 3; i++) begin
            d = rnd();
            exp_wr.push_back(d);
            master.xfer(d, 1'b1, 1'b0, q, ack);
            chk_ack(1'b0);
         end
         if (md == 1) begin
            @(negedge core_clk) rx_ready = 1'b0;
            master.xfer(8'h5a, 1'b1, 1'b0, q, ack);
            chk_ack(1'b1);
            @(negedge core_clk) rx_ready = 1'b1;
         end
         master.stop();
         master.start();
         address(1'b1, a, 1'b0);
         for (int i = 0; i < 3; i++) begin
            master.xfer(8'hff, i == 2, md == 3 && i == 2, q, ack);
            chk(q, exp_rd.size() ? exp_rd.pop_front() : 8'hxx);
         end
         master.stop();
         if (md == 0) begin
            master.start();
            address(1'b0, a ^ 10'h001, 1'b1);
            master.stop();
         end
      end
      chk(8'(exp_wr.size() + exp_rd.size()), 8'h00);
      end_sim();
   end
endmodule // i2css_core_tb_top

/* sim/i2css_master_model.sv */
// Bus master model driving SCL and SDA through open-drain pulls
module i2css_master_model (
   input  wire logic scl,    // SCL wire level
   input  wire logic sda,    // SDA wire level
   output logic      scl_oe, // Pull SCL low
   output logic      sda_oe  // Pull SDA low
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      scl_oe = 1'b0;
      sda_oe = 1'b0;
   end
   // Release SCL, then wait out a stretch of up to 50 us before the high phase
   task automatic scl_high();
      scl_oe = 1'b0;
      for (int i = 0; i < 5000 && scl !== 1'b1; i++) #10;
      #80;
   endtask
   // Data set in low phase, sampled late in high phase
   task automatic bit_io(input logic b, output logic r);
      sda_oe = !b;
      #40;
      scl_high();
      r = sda;
      scl_oe = 1'b1;
      #80;
   endtask
   task automatic start();
      sda_oe = 1'b0;
      #40;
      scl_high();
      sda_oe = 1'b1;
      #80;
      scl_oe = 1'b1;
      #80;
   endtask
   task automatic stop();
      sda_oe = 1'b1;
      #40;
      scl_high();
      sda_oe = 1'b0;
      #80;
   endtask
   // Byte MSB first; stp skips the ack bit so STOP lands in it
   task automatic xfer(input logic [7:0] d, input logic a, input logic stp,
                       output logic [7:0] q, output logic ack);
      for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
      ack = 1'b1;
      if (!stp) bit_io(a, ack);
   endtask
endmodule // i2css_master_model
